// file: hw/fuse_seq_pkg.sv
/*
  Shared constants and carrier types for the fuse program sequencer.
  Assumes a 32-bit register port with byte addresses and one fuse array word per index.
*/
package fuse_seq_pkg;
  // program word bank: block zero words 0..6, then three key blocks of eight words
  localparam int unsigned NUM_WORDS      = 31;
  localparam logic [4:0]  LAST_WORD      = 5'h1E;
  localparam logic [4:0]  KEY1_BASE      = 5'h07;
  localparam logic [4:0]  KEY2_BASE      = 5'h0F;
  localparam logic [4:0]  KEY3_BASE      = 5'h17;
  localparam logic [4:0]  CODING_WORD    = 5'h06;
  // register byte offsets
  localparam logic [7:0]  OFF_PROG_BASE  = 8'h00;
  localparam logic [7:0]  OFF_TIMING     = 8'h80;
  localparam logic [7:0]  OFF_DIVIDER    = 8'h84;
  localparam logic [7:0]  OFF_UNLOCK     = 8'h88;
  localparam logic [7:0]  OFF_COMMAND    = 8'h8C;
  localparam logic [7:0]  OFF_IRQ_RAW    = 8'h90;
  localparam logic [7:0]  OFF_IRQ_CLEAR  = 8'h94;
  localparam logic [7:0]  OFF_IRQ_ENABLE = 8'h98;
  localparam logic [7:0]  OFF_IRQ_MASKED = 8'h9C;
  localparam logic [7:0]  OFF_STATUS     = 8'hA0;
  // field positions
  localparam int unsigned TSEL0_LSB      = 0;
  localparam int unsigned TSEL1_LSB      = 8;
  localparam int unsigned DIV_LSB        = 0;
  localparam int unsigned IRQ_READ_BIT   = 0;
  localparam int unsigned IRQ_PROG_BIT   = 1;
  localparam int unsigned WP_LSB         = 0;
  localparam int unsigned WP_MSB         = 15;
  localparam int unsigned RP_LSB         = 16;
  localparam int unsigned RP_MSB         = 19;
  localparam int unsigned CRYPT_LSB      = 20;
  localparam int unsigned CRYPT_MSB      = 27;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_WIDTH_LSB = 16;
  // write-protect bit guarding each word group
  localparam logic [3:0]  WP_BLOCK0      = 4'h0;
  localparam logic [3:0]  WP_KEY1        = 4'h7;
  localparam logic [3:0]  WP_KEY2        = 4'h8;
  localparam logic [3:0]  WP_KEY3        = 4'h9;
  // keys and commands
  localparam logic [31:0] KEY_PROGRAM    = 32'h0000_5A5A;
  localparam logic [31:0] KEY_READ       = 32'h0000_5AA5;
  localparam logic [31:0] CMD_IDLE       = 32'h0000_0000;
  localparam logic [31:0] CMD_READ       = 32'h0000_0001;
  localparam logic [31:0] CMD_PROGRAM    = 32'h0000_0002;
  // key block widths per coding selector
  localparam logic [8:0]  WIDTH_NONE     = 9'h100;
  localparam logic [8:0]  WIDTH_34       = 9'h0C0;
  localparam logic [8:0]  WIDTH_REPEAT   = 9'h080;
  // reset values
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  localparam logic [1:0]  RESET_IRQ      = 2'h0;
  localparam logic [7:0]  RESET_COUNT    = 8'h00;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [4:0]  index;
    logic [31:0] mask;
    logic        burn;
    logic        read;
  } fuse_port_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_PULSE = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_READ  = 5'b10000
  } seq_state_t;
endpackage : fuse_seq_pkg

// file: hw/fuse_program_sequencer.sv
/*
  Fuse program sequencer: program-data bank, timing registers, unlock key,
  command sequencing of burn and read-back, event status and interrupt line.
  Assumes a fuse array on the same clock that burns fuseCtl.mask while fuseCtl.burn
  is high and returns the word at fuseCtl.index one cycle after fuseCtl.read.
*/
// How it works
// - word 0 holds write-protect [15:0], read-protect [19:16], crypt count [27:20].
// - each key block is eight consecutive words, word 0 low bits first.
// - a program-data bit of 1 selects its fuse bit for burning.
// - program burns only with unlock key 0x5A5A held in the key register.
// - command value 2 starts burning all selected bits.
// - burn end clears the command to zero and raises program done.
// - key 0x5AA5 then command 1 starts a read-back of the array.
// - read-back end clears the command to zero and raises read done.
// - raw status bit 1 is program done, bit 0 read done.
// - writing 1 to a clear bit clears the matching status bit.
// - enable bits 1 and 0 gate the events onto the interrupt line.
// - masked status shows the enabled and pending events.
// - any number of separate program operations is accepted.
// - a burn only moves unburned bits from 0 to 1.
// - a parameter whose write-protect bit was 1 at the last read-back gets no bits burned.
// - coding selector gives key width 256, 192 or 128 bits.
// - program done fires exactly when a burn operation finishes.
`timescale 1ns/10ps
`default_nettype none
module fuse_program_sequencer (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire fuse_seq_pkg::bus_req_t  busReq,
  output logic [31:0]                  busRdata,
  output fuse_seq_pkg::fuse_port_t     fuseCtl,
  input  wire logic [31:0]             fuseReadData,
  output logic [8:0]                   keyBlockWidth,
  output logic                         irq
);

  // write-protect bit index guarding a word
  function automatic logic [3:0] guardBit(input logic [4:0] idx);
    if (idx < fuse_seq_pkg::KEY1_BASE)
      guardBit = fuse_seq_pkg::WP_BLOCK0;
    else if (idx < fuse_seq_pkg::KEY2_BASE)
      guardBit = fuse_seq_pkg::WP_KEY1;
    else if (idx < fuse_seq_pkg::KEY3_BASE)
      guardBit = fuse_seq_pkg::WP_KEY2;
    else
      guardBit = fuse_seq_pkg::WP_KEY3;
  endfunction : guardBit

  // zero register values become one cycle so a timer never wraps
  function automatic logic [7:0] lastCount(input logic [7:0] v);
    lastCount = (v == fuse_seq_pkg::RESET_COUNT) ? 8'h00 : v - 8'h01;
  endfunction : lastCount

  // key width from the two-bit coding selector
  function automatic logic [8:0] widthOf(input logic [1:0] sel);
    case (sel)
      2'b01:   widthOf = fuse_seq_pkg::WIDTH_34;
      2'b10:   widthOf = fuse_seq_pkg::WIDTH_REPEAT;
      default: widthOf = fuse_seq_pkg::WIDTH_NONE;
    endcase
  endfunction : widthOf

  logic [31:0]             progWords [fuse_seq_pkg::NUM_WORDS];
  logic [31:0]             next_progWords [fuse_seq_pkg::NUM_WORDS];
  logic [31:0]             shadow [fuse_seq_pkg::NUM_WORDS];
  logic [31:0]             next_shadow [fuse_seq_pkg::NUM_WORDS];
  logic [31:0]             timing;
  logic [31:0]             next_timing;
  logic [31:0]             divider;
  logic [31:0]             next_divider;
  logic [31:0]             unlock;
  logic [31:0]             next_unlock;
  logic [31:0]             command;
  logic [31:0]             next_command;
  logic [1:0]              irqRaw;
  logic [1:0]              next_irqRaw;
  logic [1:0]              irqEnable;
  logic [1:0]              next_irqEnable;
  fuse_seq_pkg::seq_state_t state;
  fuse_seq_pkg::seq_state_t next_state;
  logic [7:0]              count;
  logic [7:0]              next_count;
  logic [4:0]              wordIdx;
  logic [4:0]              next_wordIdx;
  logic [1:0]              phase;
  logic [1:0]              next_phase;
  logic                    booting;
  logic                    next_booting;
  fuse_seq_pkg::fuse_port_t next_fuseCtl;
  logic [31:0]             next_busRdata;
  logic [8:0]              next_keyBlockWidth;
  logic                    next_irq;
  logic                    progDone;
  logic                    readDone;
  logic                    capture;
  logic                    cmdWrite;
  logic                    startProgram;
  logic                    startRead;
  logic [31:0]             burnMask;
  logic [15:0]             writeProtect;
  logic                    progSel;
  logic [4:0]              progIdx;

  // address decode shared by writes and reads
  assign progSel = (busReq.addr < fuse_seq_pkg::OFF_TIMING) && (busReq.addr[1:0] == 2'b00)
                   && (busReq.addr[7:2] < 6'(fuse_seq_pkg::NUM_WORDS));
  assign progIdx = busReq.addr[6:2];
  assign cmdWrite = busReq.wr && (busReq.addr == fuse_seq_pkg::OFF_COMMAND);
  // commands are taken only when idle and only with the matching key
  assign startProgram = cmdWrite && (state == fuse_seq_pkg::ST_IDLE)
                        && (busReq.wdata == fuse_seq_pkg::CMD_PROGRAM)
                        && (unlock == fuse_seq_pkg::KEY_PROGRAM);
  assign startRead = cmdWrite && (state == fuse_seq_pkg::ST_IDLE)
                     && (busReq.wdata == fuse_seq_pkg::CMD_READ)
                     && (unlock == fuse_seq_pkg::KEY_READ);
  assign writeProtect = shadow[0][fuse_seq_pkg::WP_MSB:fuse_seq_pkg::WP_LSB];
  // selected, not yet burned, not protected
  assign burnMask = progWords[wordIdx] & ~shadow[wordIdx]
                    & {32{~writeProtect[guardBit(wordIdx)]}};

  // software registers; hardware event set wins over a clear in the same cycle
  always_comb begin
    next_progWords = progWords;
    next_timing    = timing;
    next_divider   = divider;
    next_unlock    = unlock;
    next_irqRaw    = irqRaw;
    next_irqEnable = irqEnable;
    if (busReq.wr) begin
      if (progSel) begin
        next_progWords[progIdx] = busReq.wdata;
      end else if (busReq.addr == fuse_seq_pkg::OFF_TIMING) begin
        next_timing = busReq.wdata;
      end else if (busReq.addr == fuse_seq_pkg::OFF_DIVIDER) begin
        next_divider = busReq.wdata;
      end else if (busReq.addr == fuse_seq_pkg::OFF_UNLOCK) begin
        next_unlock = busReq.wdata;
      end else if (busReq.addr == fuse_seq_pkg::OFF_IRQ_CLEAR) begin
        next_irqRaw = irqRaw & ~busReq.wdata[1:0];
      end else if (busReq.addr == fuse_seq_pkg::OFF_IRQ_ENABLE) begin
        next_irqEnable = busReq.wdata[1:0];
      end
    end
    if (progDone) next_irqRaw[fuse_seq_pkg::IRQ_PROG_BIT] = 1'b1;
    if (readDone) next_irqRaw[fuse_seq_pkg::IRQ_READ_BIT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < fuse_seq_pkg::NUM_WORDS; i++) progWords[i] <= fuse_seq_pkg::RESET_WORD;
      timing    <= fuse_seq_pkg::RESET_WORD;
      divider   <= fuse_seq_pkg::RESET_WORD;
      unlock    <= fuse_seq_pkg::RESET_WORD;
      irqRaw    <= fuse_seq_pkg::RESET_IRQ;
      irqEnable <= fuse_seq_pkg::RESET_IRQ;
    end else begin
      progWords <= next_progWords;
      timing    <= next_timing;
      divider   <= next_divider;
      unlock    <= next_unlock;
      irqRaw    <= next_irqRaw;
      irqEnable <= next_irqEnable;
    end
  end

  // sequencer: per word setup, burn pulse, hold; read-back in three phases
  always_comb begin
    next_state   = state;
    next_count   = count;
    next_wordIdx = wordIdx;
    next_phase   = phase;
    next_booting = booting;
    next_command = command;
    next_fuseCtl = fuseCtl;
    next_fuseCtl.read = 1'b0;
    progDone = 1'b0;
    readDone = 1'b0;
    capture  = 1'b0;
    case (state)
      fuse_seq_pkg::ST_IDLE: begin
        next_fuseCtl.burn = 1'b0;
        next_count   = fuse_seq_pkg::RESET_COUNT;
        next_wordIdx = 5'h00;
        next_phase   = 2'h0;
        if (startProgram) begin
          next_command = fuse_seq_pkg::CMD_PROGRAM;
          next_state   = fuse_seq_pkg::ST_SETUP;
        end else if (startRead) begin
          next_command = fuse_seq_pkg::CMD_READ;
          next_state   = fuse_seq_pkg::ST_READ;
        end
      end
      fuse_seq_pkg::ST_SETUP: begin
        next_fuseCtl.index = wordIdx;
        next_fuseCtl.mask  = burnMask;
        if (count == lastCount(timing[fuse_seq_pkg::TSEL0_LSB +: 8])) begin
          next_count        = fuse_seq_pkg::RESET_COUNT;
          next_fuseCtl.burn = |burnMask;
          next_state        = fuse_seq_pkg::ST_PULSE;
        end else begin
          next_count = count + 8'h01;
        end
      end
      fuse_seq_pkg::ST_PULSE: begin
        // pulse width taken from the divider register, one cycle per count
        if (count == lastCount(divider[fuse_seq_pkg::DIV_LSB +: 8])) begin
          next_count        = fuse_seq_pkg::RESET_COUNT;
          next_fuseCtl.burn = 1'b0;
          next_state        = fuse_seq_pkg::ST_HOLD;
        end else begin
          next_count = count + 8'h01;
        end
      end
      fuse_seq_pkg::ST_HOLD: begin
        if (count == lastCount(timing[fuse_seq_pkg::TSEL1_LSB +: 8])) begin
          next_count = fuse_seq_pkg::RESET_COUNT;
          if (wordIdx == fuse_seq_pkg::LAST_WORD) begin
            next_command = fuse_seq_pkg::CMD_IDLE;
            progDone     = 1'b1;
            next_state   = fuse_seq_pkg::ST_IDLE;
          end else begin
            next_wordIdx = wordIdx + 5'h01;
            next_state   = fuse_seq_pkg::ST_SETUP;
          end
        end else begin
          next_count = count + 8'h01;
        end
      end
      fuse_seq_pkg::ST_READ: begin
        next_fuseCtl.index = wordIdx;
        if (phase == 2'h0) begin
          next_fuseCtl.read = 1'b1;
          next_phase        = 2'h1;
        end else if (phase == 2'h1) begin
          next_phase = 2'h2;
        end else begin
          capture    = 1'b1;
          next_phase = 2'h0;
          if (wordIdx == fuse_seq_pkg::LAST_WORD) begin
            next_command = fuse_seq_pkg::CMD_IDLE;
            readDone     = ~booting; // the load after reset raises no event
            next_booting = 1'b0;
            next_state   = fuse_seq_pkg::ST_IDLE;
          end else begin
            next_wordIdx = wordIdx + 5'h01;
          end
        end
      end
      default: begin
        next_state = fuse_seq_pkg::ST_IDLE;
      end
    endcase
  end

  // reset starts a silent read-back so protection sees the real fuse state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state   <= fuse_seq_pkg::ST_READ;
      count   <= fuse_seq_pkg::RESET_COUNT;
      wordIdx <= 5'h00;
      phase   <= 2'h0;
      booting <= 1'b1;
      command <= fuse_seq_pkg::CMD_IDLE;
      fuseCtl <= '0;
    end else begin
      state   <= next_state;
      count   <= next_count;
      wordIdx <= next_wordIdx;
      phase   <= next_phase;
      booting <= next_booting;
      command <= next_command;
      fuseCtl <= next_fuseCtl;
    end
  end

  // fuse shadow only changes by read-back, never by the burn itself
  always_comb begin
    next_shadow = shadow;
    if (capture) next_shadow[wordIdx] = fuseReadData;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < fuse_seq_pkg::NUM_WORDS; i++) shadow[i] <= fuse_seq_pkg::RESET_WORD;
    end else begin
      shadow <= next_shadow;
    end
  end

  // read data, interrupt line and key width; unmapped reads return zero
  always_comb begin
    next_busRdata = fuse_seq_pkg::RESET_WORD;
    if (busReq.rd) begin
      if (progSel) begin
        next_busRdata = progWords[progIdx];
      end else if (busReq.addr == fuse_seq_pkg::OFF_TIMING) begin
        next_busRdata = timing;
      end else if (busReq.addr == fuse_seq_pkg::OFF_DIVIDER) begin
        next_busRdata = divider;
      end else if (busReq.addr == fuse_seq_pkg::OFF_UNLOCK) begin
        next_busRdata = unlock;
      end else if (busReq.addr == fuse_seq_pkg::OFF_COMMAND) begin
        next_busRdata = command;
      end else if (busReq.addr == fuse_seq_pkg::OFF_IRQ_RAW) begin
        next_busRdata = {30'h0000_0000, irqRaw};
      end else if (busReq.addr == fuse_seq_pkg::OFF_IRQ_ENABLE) begin
        next_busRdata = {30'h0000_0000, irqEnable};
      end else if (busReq.addr == fuse_seq_pkg::OFF_IRQ_MASKED) begin
        next_busRdata = {30'h0000_0000, irqRaw & irqEnable};
      end else if (busReq.addr == fuse_seq_pkg::OFF_STATUS) begin
        next_busRdata[fuse_seq_pkg::STAT_BUSY_BIT] = (state != fuse_seq_pkg::ST_IDLE);
        next_busRdata[fuse_seq_pkg::STAT_WIDTH_LSB +: 9] = keyBlockWidth;
      end
    end
    next_irq = |(irqRaw & irqEnable);
    next_keyBlockWidth = widthOf(shadow[fuse_seq_pkg::CODING_WORD][1:0]);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busRdata      <= fuse_seq_pkg::RESET_WORD;
      irq           <= 1'b0;
      keyBlockWidth <= fuse_seq_pkg::WIDTH_NONE;
    end else begin
      busRdata      <= next_busRdata;
      irq           <= next_irq;
      keyBlockWidth <= next_keyBlockWidth;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  burn_unburned_a: assert property (fuseCtl.burn |->
    ((fuseCtl.mask & shadow[fuseCtl.index]) == 32'h0000_0000))
    else $error("burn selects an already burned bit");
  protect_holds_a: assert property (fuseCtl.burn |->
    !writeProtect[guardBit(fuseCtl.index)])
    else $error("burn on a write-protected word");
  prog_start_a: assert property (startProgram |=>
    (command == fuse_seq_pkg::CMD_PROGRAM) && (state == fuse_seq_pkg::ST_SETUP))
    else $error("program command not started");
  prog_done_a: assert property (progDone |=>
    (command == fuse_seq_pkg::CMD_IDLE) && irqRaw[fuse_seq_pkg::IRQ_PROG_BIT])
    else $error("program end did not clear command or set status");
  read_done_a: assert property ((state == fuse_seq_pkg::ST_READ) && (phase == 2'h2)
    && (wordIdx == fuse_seq_pkg::LAST_WORD) && !booting |=>
    (command == fuse_seq_pkg::CMD_IDLE) && irqRaw[fuse_seq_pkg::IRQ_READ_BIT])
    else $error("read-back end did not clear command or set status");
  bad_key_a: assert property (cmdWrite && (state == fuse_seq_pkg::ST_IDLE)
    && !startProgram && !startRead |=> (command == fuse_seq_pkg::CMD_IDLE))
    else $error("command taken without its key");
  irq_clear_a: assert property (busReq.wr && (busReq.addr == fuse_seq_pkg::OFF_IRQ_CLEAR)
    && busReq.wdata[fuse_seq_pkg::IRQ_PROG_BIT] && !progDone |=>
    !irqRaw[fuse_seq_pkg::IRQ_PROG_BIT])
    else $error("clear did not drop program done");
  irq_line_a: assert property (##1 (irq == $past(|(irqRaw & irqEnable))))
    else $error("interrupt line does not follow enabled status");
  pulse_len_a: assert property ($rose(fuseCtl.burn) && (divider[7:0] == 8'h02) |->
    fuseCtl.burn [*2] ##1 !fuseCtl.burn)
    else $error("burn pulse length differs from divider");

  prog_seen_c: cover property (progDone);
  read_seen_c: cover property (readDone);
  irq_seen_c:  cover property ($rose(irq));
  refuse_c:    cover property (cmdWrite && (state == fuse_seq_pkg::ST_IDLE) && !startProgram);

endmodule : fuse_program_sequencer
`default_nettype wire

// file: verif/fuse_array_model.sv
/*
  fuse array model: 31 one-way words that burn and read back.
  assumes the sequencer clock and the fuse port struct of the package.
*/
`timescale 1ns/10ps
`default_nettype none
module fuse_array_model (
  input  wire logic                     clk,
  input  wire fuse_seq_pkg::fuse_port_t fuseCtl,
  output logic [31:0]                   fuseReadData
);
  logic [31:0] mem [31];
  // blank fuses; nonvolatile, so no reset
  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    fuseReadData = 32'h0000_0000;
  end
  // a burn only sets bits, never clears one
  always @(posedge clk) begin
    if (fuseCtl.burn) mem[fuseCtl.index] <= mem[fuseCtl.index] | fuseCtl.mask;
  end
  // word valid only the cycle after a read; toggles otherwise so stale data shows
  always @(posedge clk) begin
    if (fuseCtl.read) fuseReadData <= mem[fuseCtl.index];
    else fuseReadData <= ~fuseReadData;
  end
endmodule : fuse_array_model
`default_nettype wire

// file: verif/fuse_program_sequencer_bench.sv
/*
  self-checking bench for the fuse program sequencer with an array model.
  assumes the register offsets and constants of fuse_seq_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
module fuse_program_sequencer_bench;
  logic                     clk     = 1'b0;
  logic                     rst_n   = 1'b0;
  fuse_seq_pkg::bus_req_t   busReq  = '0;
  logic [31:0]              busRdata;
  fuse_seq_pkg::fuse_port_t fuseCtl;
  logic [31:0]              fuseReadData;
  logic [8:0]               keyBlockWidth;
  logic                     irq;
  int                       n_fail  = 0;
  int                       n_tests = 0;
  logic [31:0]              expWord [31];
  logic [31:0]              pgWord  [31];
  logic [31:0]              rdVal;
  logic [31:0]              tCfg [3] = '{32'h0000_FFFA, 32'h0000_FFA0, 32'h0000_8050};
  logic [31:0]              dCfg [3] = '{32'h0000_0034, 32'h0000_0050, 32'h0000_00A0};
  logic [7:0]               zAddr [4] = '{8'h90, 8'h9C, 8'h8C, 8'hC0};

  always #20 clk = ~clk;

  fuse_program_sequencer uut (.clk(clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
    .fuseCtl(fuseCtl), .fuseReadData(fuseReadData), .keyBlockWidth(keyBlockWidth), .irq(irq));
  fuse_array_model arrayModel (.clk(clk), .fuseCtl(fuseCtl), .fuseReadData(fuseReadData));

  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic check32(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask : check32

  task automatic checkBit(input logic got, input logic want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("wrong value at %0t: flag %b want %b", $time, got, want);
    end
  endtask : checkBit

  // one-cycle strobes, changed just after the edge
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 d = busRdata;
  endtask : rdReg

  // guard bit of each word group, as software sees it
  function automatic int guardBit(input int i);
    return (i < 7) ? 0 : (i < 15) ? 7 : (i < 23) ? 8 : 9;
  endfunction : guardBit

  // key and command, then poll until the command clears
  task automatic runCmd(input logic [31:0] key, input logic [31:0] cmd);
    wrReg(fuse_seq_pkg::OFF_UNLOCK, key);
    wrReg(fuse_seq_pkg::OFF_COMMAND, cmd);
    rdReg(fuse_seq_pkg::OFF_COMMAND, rdVal);
    check32(rdVal, cmd);
    // the slow round needs about 17300 cycles, each poll takes two
    for (int k = 0; k < 12000 && rdVal !== 32'h0000_0000; k++) rdReg(8'h8C, rdVal);
    check32(rdVal, fuse_seq_pkg::CMD_IDLE);
    rdReg(fuse_seq_pkg::OFF_IRQ_RAW, rdVal);
    checkBit(rdVal[(cmd == fuse_seq_pkg::CMD_PROGRAM) ? 1 : 0], 1'b1);
  endtask : runCmd

  // random fresh bits only; guard and coding bits are set by hand
  task automatic fillRandom;
    foreach (pgWord[i]) pgWord[i] = $urandom() & ~expWord[i];
    pgWord[0] &= 32'hFFFF_FC7E;
    pgWord[6] &= 32'hFFFF_FFFC;
  endtask : fillRandom

  // full operation: fill, burn, read back, compare the array, tidy the words
  task automatic burnRound(input logic [31:0] timing, input logic [31:0] div);
    logic [31:0] guard;
    guard = expWord[0];
    wrReg(fuse_seq_pkg::OFF_TIMING, timing);
    wrReg(fuse_seq_pkg::OFF_DIVIDER, div);
    for (int i = 0; i < 31; i++) wrReg(8'(4 * i), pgWord[i]);
    runCmd(fuse_seq_pkg::KEY_PROGRAM, fuse_seq_pkg::CMD_PROGRAM);
    runCmd(fuse_seq_pkg::KEY_READ, fuse_seq_pkg::CMD_READ);
    for (int i = 0; i < 31; i++) begin
      if (!guard[guardBit(i)]) expWord[i] |= pgWord[i];
      check32(arrayModel.mem[i], expWord[i]);
      if (pgWord[i] !== 32'h0000_0000) wrReg(8'(4 * i), 32'h0000_0000);
    end
  endtask : burnRound

  // hang guard, well beyond the slow round
  initial begin
    #(40 * 60000);
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(62));
    foreach (expWord[i]) expWord[i] = 32'h0000_0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // boot read-back must finish before commands count
    rdReg(fuse_seq_pkg::OFF_STATUS, rdVal);
    for (int k = 0; k < 200 && rdVal[0] !== 1'b0; k++) rdReg(8'hA0, rdVal);
    checkBit(rdVal[0], 1'b0);
    check32(32'(keyBlockWidth), 32'(fuse_seq_pkg::WIDTH_NONE));
    foreach (zAddr[i]) begin
      rdReg(zAddr[i], rdVal);
      check32(rdVal, 32'h0000_0000);
    end
    // timing settings for each bus rate
    for (int i = 0; i < 3; i++) begin
      wrReg(fuse_seq_pkg::OFF_TIMING, tCfg[i]);
      wrReg(fuse_seq_pkg::OFF_DIVIDER, dCfg[i]);
      rdReg(fuse_seq_pkg::OFF_TIMING, rdVal);
      check32(rdVal, tCfg[i]);
      rdReg(fuse_seq_pkg::OFF_DIVIDER, rdVal);
      check32(rdVal, dCfg[i]);
    end
    // commands without the matching key are dropped
    for (int i = 0; i < 3; i++) begin
      wrReg(fuse_seq_pkg::OFF_UNLOCK,
            (i == 2) ? fuse_seq_pkg::KEY_PROGRAM : fuse_seq_pkg::KEY_READ);
      wrReg(fuse_seq_pkg::OFF_COMMAND,
            (i == 2) ? fuse_seq_pkg::CMD_READ : fuse_seq_pkg::CMD_PROGRAM);
      rdReg(fuse_seq_pkg::OFF_COMMAND, rdVal);
      check32(rdVal, fuse_seq_pkg::CMD_IDLE);
    end
    wrReg(fuse_seq_pkg::OFF_IRQ_ENABLE, 32'h0000_0002);
    fillRandom();
    burnRound(32'h0000_0101, 32'h0000_0001);
    // enable gating, masked view, write-one-to-clear
    rdReg(fuse_seq_pkg::OFF_IRQ_MASKED, rdVal);
    check32(rdVal, 32'h0000_0002);
    checkBit(irq, 1'b1);
    wrReg(fuse_seq_pkg::OFF_IRQ_CLEAR, 32'h0000_0002);
    rdReg(fuse_seq_pkg::OFF_IRQ_RAW, rdVal);
    check32(rdVal, 32'h0000_0001);
    checkBit(irq, 1'b0);
    wrReg(fuse_seq_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    rdReg(fuse_seq_pkg::OFF_IRQ_MASKED, rdVal);
    check32(rdVal, 32'h0000_0001);
    checkBit(irq, 1'b1);
    wrReg(fuse_seq_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
    rdReg(fuse_seq_pkg::OFF_IRQ_RAW, rdVal);
    check32(rdVal, 32'h0000_0000);
    checkBit(irq, 1'b0);
    // second burn on the same words, then guard key one and pick repeat coding
    // two-cycle burn pulse so the pulse length check has work to do
    fillRandom();
    burnRound(32'h0000_0101, 32'h0000_0002);
    fillRandom();
    pgWord[0] |= 32'h0000_0080;
    pgWord[6] |= 32'h0000_0002;
    burnRound(32'h0000_0000, 32'h0000_0000);
    check32(32'(keyBlockWidth), 32'(fuse_seq_pkg::WIDTH_REPEAT));
    // slow real timing; key one words must stay untouched
    fillRandom();
    pgWord[6] |= 32'h0000_0001;
    burnRound(32'h0000_FFFA, 32'h0000_0034);
    check32(32'(keyBlockWidth), 32'(fuse_seq_pkg::WIDTH_NONE));
    stop_test();
  end
endmodule : fuse_program_sequencer_bench
`default_nettype wire
